// ### pkg/nand_host_consts.vh
// Purpose: Constants for the asynchronous NAND host controller.
// Assumes: 25 MHz system clock, 40 ns period.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH

`define CLK_PERIOD_NS      40
`define CLK_MHZ            25
// Power-on wait without watching the busy line, in microseconds.
`define POWERUP_WAIT_US    100
`define POWERUP_WAIT_CYC   (`POWERUP_WAIT_US * `CLK_MHZ)
// Busy-line validity wait after supply ramp start, in microseconds.
`define BUSY_VALID_US      50
`define BUSY_VALID_CYC     (`BUSY_VALID_US * `CLK_MHZ)
// Reset busy time, in microseconds (1 ms).
`define RESET_BUSY_US      1000
`define RESET_BUSY_CYC     (`RESET_BUSY_US * `CLK_MHZ)
// Write-protect settle time, in nanoseconds.
`define PROTECT_SETTLE_NS  100
`define PROTECT_SETTLE_CYC ((`PROTECT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CMD_RESET          8'hff
`define CMD_READ_MODE      8'h00
`define CMD_STATUS         8'h70
`define CMD_STATUS_ENH     8'h78

// Byte operation kinds on the user port.
`define OP_CMD             2'h0
`define OP_ADDR            2'h1
`define OP_WRITE           2'h2
`define OP_READ            2'h3

`define CNT_W              16

// Five address bytes, byte 0 in the low lane.
`define ADDR_BYTES_W       40
// Bit positions that belong to the address space; all others go out low.
`define ADDR_SPACE_MASK    40'h01ffff1fff
`endif

// ### logic/nand_async_host.v
// Purpose: Host-side controller for an asynchronous multiplexed NAND bus.
// Assumes: Pins are sampled synchronously to clk_sys_in; one target.
// Notes:   The strobe low phase lasts one clock (40 ns); a byte cycle takes three clocks, 120 ns.
`timescale 1ns/1ps
`include "nand_host_consts.vh"

module nand_async_host #(
  parameter [15:0] POWERUP_CYC = `POWERUP_WAIT_CYC,
  parameter [15:0] BUSYVAL_CYC = `BUSY_VALID_CYC,
  parameter [15:0] RSTBUSY_CYC = `RESET_BUSY_CYC
) (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rstn_in,
  // User byte request port
  input  wire        req_valid_in,
  input  wire [1:0]  req_op_in,
  input  wire [7:0]  req_data_in,
  input  wire        req_ignore_busy_in,
  output reg         req_ready_out,
  output reg         rsp_valid_out,
  output reg  [7:0]  rsp_data_out,
  output reg         init_done_out,
  // Address formatting helper
  input  wire        addr_load_in,
  input  wire [12:0] addr_column_in,
  input  wire [5:0]  addr_page_in,
  input  wire [10:0] addr_block_in,
  // Write-protect request
  input  wire        protect_req_in,
  // NAND pins
  output reg         chip_sel_n_out,
  output reg         cmd_latch_out,
  output reg         addr_latch_out,
  output reg         write_strobe_n_out,
  output reg         read_strobe_n_out,
  output reg         write_protect_n_out,
  input  wire [7:0]  io_in,
  output reg  [7:0]  io_out,
  output reg         io_oe_out,
  input  wire        ready_busy_n_in,
  // Formatted address bytes
  output reg  [39:0] addr_bytes_out
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [2:0] ST_PWR    = 3'h0;
  localparam [2:0] ST_RST    = 3'h1;
  localparam [2:0] ST_RSTWT  = 3'h2;
  localparam [2:0] ST_IDLE   = 3'h3;
  localparam [2:0] ST_WLOW   = 3'h4;
  localparam [2:0] ST_RLOW   = 3'h5;
  localparam [2:0] ST_DONE   = 3'h6;
  localparam [2:0] ST_WP     = 3'h7;

  reg [2:0]          state;
  reg [`CNT_W-1:0]   cnt;
  reg [1:0]          op;
  reg                status_mode;

  wire [12:0] col_fix;
  // Bits 11:8 forced low when bit 12 set, as the device requires.
  assign col_fix = addr_column_in[12] ? {1'b1, 4'h0, addr_column_in[7:0]}
                                      : addr_column_in;

  // ----------------------------------------------------------------------
  // Address space mask
  // ----------------------------------------------------------------------
  wire [`ADDR_BYTES_W-1:0] addr_raw;
  wire [`ADDR_BYTES_W-1:0] addr_keep;
  wire [`ADDR_BYTES_W-1:0] addr_next;

  // Byte 0 first; reserved positions are zero in the raw layout already.
  assign addr_raw  = {7'h00, addr_block_in[10],
                      addr_block_in[9:2],
                      addr_block_in[1:0], addr_page_in,
                      3'h0, col_fix[12:8],
                      col_fix[7:0]};
  assign addr_keep = `ADDR_SPACE_MASK;

  // Each bit is gated on its own, so a later change to the field layout
  // cannot leak a stray one into a position the target treats as reserved.
  genvar bit_i;
  generate
    for (bit_i = 0; bit_i < `ADDR_BYTES_W; bit_i = bit_i + 1) begin : g_addr_mask
      assign addr_next[bit_i] = addr_raw[bit_i] & addr_keep[bit_i];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  wire is_read_op;
  wire is_cmd_op;
  wire is_addr_op;
  wire is_status_cmd;
  wire is_read_mode_cmd;
  wire protect_change;
  wire target_open;

  assign is_read_op       = (req_op_in == `OP_READ);
  assign is_cmd_op        = (req_op_in == `OP_CMD);
  assign is_addr_op       = (req_op_in == `OP_ADDR);
  assign is_status_cmd    = is_cmd_op && (req_data_in == `CMD_STATUS ||
                                          req_data_in == `CMD_STATUS_ENH);
  assign is_read_mode_cmd = is_cmd_op && (req_data_in == `CMD_READ_MODE);
  // A protect change must not cut into a sequence, so it waits for ready.
  assign protect_change   = (protect_req_in != write_protect_n_out) && ready_busy_n_in;
  // A busy target is only addressed in status mode or with ignore-busy set; all else waits.
  assign target_open      = ready_busy_n_in || req_ignore_busy_in || status_mode;

  // ----------------------------------------------------------------------
  // Byte cycle timing
  // ----------------------------------------------------------------------
  // A write byte takes three clocks: strobe low with lines set, strobe
  // high (the target latches here), then latches and drive released.
  // A read byte takes the same: strobe low, strobe high with the byte
  // sampled, then ready again. With 120 ns per cycle the byte is stable
  // at the rising strobe, which spares a second capture register.

  // ----------------------------------------------------------------------
  // Address byte formatting
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_bytes_out <= 40'h0;
    end else if (addr_load_in) begin
      addr_bytes_out <= addr_next;
    end
  end

  // ----------------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state               <= ST_PWR;
      cnt                 <= {`CNT_W{1'b0}};
      op                  <= `OP_CMD;
      status_mode         <= 1'b0;
      req_ready_out       <= 1'b0;
      rsp_valid_out       <= 1'b0;
      rsp_data_out        <= 8'h00;
      init_done_out       <= 1'b0;
      chip_sel_n_out      <= 1'b1;
      cmd_latch_out       <= 1'b0;
      addr_latch_out      <= 1'b0;
      write_strobe_n_out  <= 1'b1;
      read_strobe_n_out   <= 1'b1;
      write_protect_n_out <= 1'b0;
      io_out              <= 8'h00;
      io_oe_out           <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state)
        ST_PWR: begin
          // Leave after the fixed wait, or earlier once the busy-valid time has passed with a high busy line.
          cnt <= cnt + 1'b1;
          if (cnt >= POWERUP_CYC ||
              (cnt >= BUSYVAL_CYC && ready_busy_n_in)) begin
            cnt   <= {`CNT_W{1'b0}};
            state <= ST_RST;
          end
        end
        ST_RST: begin
          // Interface is active by default, so reset goes out directly.
          chip_sel_n_out     <= 1'b0;
          cmd_latch_out      <= 1'b1;
          io_out             <= `CMD_RESET;
          io_oe_out          <= 1'b1;
          write_strobe_n_out <= ~write_strobe_n_out;
          // Latch and data must still stand as the strobe rises, so they
          // are dropped only once the busy wait has begun.
          if (!write_strobe_n_out) begin
            state <= ST_RSTWT;
          end
        end
        ST_RSTWT: begin
          // Fixed busy time as a minimum, then held until the busy line shows ready.
          cmd_latch_out <= 1'b0;
          io_oe_out     <= 1'b0;
          cnt           <= cnt + 1'b1;
          if (cnt >= RSTBUSY_CYC && ready_busy_n_in) begin
            cnt                 <= {`CNT_W{1'b0}};
            chip_sel_n_out      <= 1'b1;
            init_done_out       <= 1'b1;
            req_ready_out       <= 1'b1;
            state               <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          cmd_latch_out  <= 1'b0;
          addr_latch_out <= 1'b0;
          io_oe_out      <= 1'b0;
          if (protect_change) begin
            write_protect_n_out <= protect_req_in;
            req_ready_out       <= 1'b0;
            cnt                 <= {`CNT_W{1'b0}};
            state               <= ST_WP;
          end else if (req_valid_in && target_open) begin
            req_ready_out  <= 1'b0;
            op             <= req_op_in;
            chip_sel_n_out <= 1'b0;
            if (is_read_op) begin
              read_strobe_n_out <= 1'b0;
              state             <= ST_RLOW;
            end else begin
              cmd_latch_out      <= is_cmd_op;
              addr_latch_out     <= is_addr_op;
              io_out             <= req_data_in;
              io_oe_out          <= 1'b1;
              write_strobe_n_out <= 1'b0;
              state              <= ST_WLOW;
              // Status mode lasts until read mode is issued again.
              if (is_status_cmd)
                status_mode <= 1'b1;
              else if (is_read_mode_cmd)
                status_mode <= 1'b0;
            end
          end else if (!req_valid_in) begin
            // Release select between requests so the device may idle.
            chip_sel_n_out <= 1'b1;
          end
        end
        ST_WLOW: begin
          // Rising edge latches while control lines still hold.
          write_strobe_n_out <= 1'b1;
          state              <= ST_DONE;
        end
        ST_RLOW: begin
          // Cycle is 120 ns, so the byte is taken at the rising edge.
          read_strobe_n_out <= 1'b1;
          rsp_data_out      <= io_in;
          rsp_valid_out     <= 1'b1;
          state             <= ST_DONE;
        end
        ST_DONE: begin
          cmd_latch_out  <= 1'b0;
          addr_latch_out <= 1'b0;
          io_oe_out      <= 1'b0;
          req_ready_out  <= 1'b1;
          state          <= ST_IDLE;
        end
        ST_WP: begin
          cnt <= cnt + 1'b1;
          if (cnt >= `PROTECT_SETTLE_CYC) begin
            req_ready_out <= 1'b1;
            state         <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_PWR;
        end
      endcase
    end
  end

endmodule // nand_async_host

// ### testbench/nand_host_asserts.sv
// Purpose: Pin and formatter assertions for the NAND host.
// Assumes: One clock domain.
// Notes:   Watches design outputs and the inputs they are checked against.
`timescale 1ns/1ps
module nand_host_asserts (
  input wire        clk_sys_in, rstn_in, addr_load_in, init_done_out, rsp_valid_out,
  input wire        chip_sel_n_out, cmd_latch_out, addr_latch_out, write_strobe_n_out,
  input wire        read_strobe_n_out, write_protect_n_out, io_oe_out, ready_busy_n_in,
  input wire [7:0]  io_in, io_out, rsp_data_out,
  input wire [12:0] addr_column_in,
  input wire [5:0]  addr_page_in,
  input wire [10:0] addr_block_in,
  input wire [39:0] addr_bytes_out
);
  reg [29:0] ld_q;
  always @(posedge clk_sys_in) ld_q <= {addr_block_in, addr_page_in, addr_column_in};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  cmd_strobe_a: assert property ($rose(write_strobe_n_out) && cmd_latch_out |->
    !chip_sel_n_out && !addr_latch_out && read_strobe_n_out) else $error("command strobe");
  addr_strobe_a: assert property ($rose(write_strobe_n_out) && addr_latch_out |->
    !chip_sel_n_out && !cmd_latch_out && read_strobe_n_out) else $error("address strobe");
  host_drive_a: assert property (!write_strobe_n_out |-> io_oe_out) else $error("drive");
  read_phase_a: assert property (!read_strobe_n_out |-> !chip_sel_n_out && !io_oe_out &&
    !cmd_latch_out && !addr_latch_out && write_strobe_n_out) else $error("read phase");
  read_sample_a: assert property ($rose(read_strobe_n_out) |-> rsp_valid_out &&
    rsp_data_out == $past(io_in)) else $error("read sample");
  first_reset_a: assert property ($rose(write_strobe_n_out) && !init_done_out |->
    cmd_latch_out && io_out == 8'hff) else $error("first command");
  busy_valid_a: assert property ($fell(write_strobe_n_out) && !init_done_out |->
    ready_busy_n_in) else $error("reset before ready");
  protect_hold_a: assert property (!init_done_out |-> !write_protect_n_out)
    else $error("protect early");
  protect_settle_a: assert property ($changed(write_protect_n_out) |->
    write_strobe_n_out [*3]) else $error("protect settle");
  addr_format_a: assert property ($past(addr_load_in) |-> addr_bytes_out ==
    {7'h0, ld_q[29:13], 3'h0, ld_q[12], (ld_q[12] ? 4'h0 : ld_q[11:8]), ld_q[7:0]})
    else $error("address bytes");
  cover property ($rose(init_done_out));
  cover property (rsp_valid_out && !ready_busy_n_in);
  cover property ($rose(write_protect_n_out));
endmodule // nand_host_asserts
bind nand_async_host nand_host_asserts chk_u (.clk_sys_in, .rstn_in, .addr_load_in,
  .init_done_out, .rsp_valid_out, .chip_sel_n_out, .cmd_latch_out, .addr_latch_out,
  .write_strobe_n_out, .read_strobe_n_out, .write_protect_n_out, .io_oe_out,
  .ready_busy_n_in, .io_in, .io_out, .rsp_data_out, .addr_column_in, .addr_page_in,
  .addr_block_in, .addr_bytes_out);

// ### testbench/nand_dev_model.sv
// Purpose: Behavioural NAND target on the far side of the host.
// Assumes: One die; busy time shortened by parameter.
// Notes:   Released data lines show the inverse of the last byte.
`timescale 1ns/1ps
module nand_dev_model #(
  parameter BUSY_NS = 1500
) (
  input  wire       cs_n_in, cle_in, ale_in, we_n_in, re_n_in, wp_n_in,
  input  wire [7:0] io_in,
  output reg  [7:0] io_out,
  output wire       rb_n_out
);
  reg [7:0] mem [0:255];
  reg [7:0] ptr, first_cmd, last_cmd;
  reg       busy, stat, got;
  integer   acnt;
  initial begin
    busy = 0; stat = 0; got = 0; ptr = 0; acnt = 0; io_out = 8'h5a; last_cmd = 0;
  end
  assign rb_n_out = busy ? 1'b0 : 1'bz;
  always @(posedge we_n_in) if (!cs_n_in && re_n_in) begin
    if (cle_in && !ale_in && (!busy || io_in == 8'h70 || io_in == 8'h78)) begin
      if (!got) first_cmd = io_in;
      got = 1;
      last_cmd = io_in;
      acnt = 0;
      if (io_in == 8'h70 || io_in == 8'h78) stat = 1;
      if (io_in == 8'h00) stat = 0;
      if (io_in == 8'hff || (io_in == 8'h10 && wp_n_in)) begin
        busy = 1;
        busy <= #(BUSY_NS) 1'b0;
      end
    end else if (ale_in && !cle_in && (!busy || last_cmd == 8'h78)) begin
      if (acnt == 0) ptr = io_in;
      acnt = acnt + 1;
    end else if (!ale_in && !cle_in && !busy) begin
      mem[ptr] = io_in;
      ptr = ptr + 1;
    end
  end
  always @(negedge re_n_in) if (!cs_n_in && !cle_in && !ale_in && we_n_in) begin
    if (stat) io_out = {wp_n_in, !busy, 6'h00};
    else if (!busy) begin
      io_out = mem[ptr];
      ptr = ptr + 1;
    end
  end
  always @(posedge re_n_in) io_out = ~io_out;
endmodule // nand_dev_model

// ### testbench/nand_async_host_bench.sv
// Purpose: Self-checking bench for the NAND host controller.
// Assumes: Small power-on counts.
// Notes:   Requests are spaced at least eight cycles apart.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked = checked + 1; if ((a) !== (e)) begin fails = fails + 1; \
  $display("BAD %s expected %h seen %h", nm, e, a); end end
module nand_async_host_bench;
  reg         clk_sys_in = 0, rstn_in = 0, vld = 0, ib = 0, ld = 0, prot = 0;
  reg  [1:0]  op = 0;
  reg  [7:0]  dat = 0, rd;
  reg  [12:0] col = 0;
  reg  [5:0]  page = 0;
  reg  [10:0] blk = 0;
  integer     fails = 0, checked = 0, i;
  wire        rdy, rv, done, cs_n, cle, ale, we_n, re_n, wp_n, oe;
  wire [7:0]  rdat, io_h, io_d, io_bus;
  wire [39:0] ab;
  tri1        rb_n;
  assign io_bus = oe ? io_h : io_d;
  always #20 clk_sys_in = ~clk_sys_in;
  nand_async_host #(.POWERUP_CYC(16'd20), .BUSYVAL_CYC(16'd10), .RSTBUSY_CYC(16'd50)) dut_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_valid_in(vld), .req_op_in(op),
    .req_data_in(dat), .req_ignore_busy_in(ib), .req_ready_out(rdy), .rsp_valid_out(rv),
    .rsp_data_out(rdat), .init_done_out(done), .addr_load_in(ld), .addr_column_in(col),
    .addr_page_in(page), .addr_block_in(blk), .protect_req_in(prot), .chip_sel_n_out(cs_n),
    .cmd_latch_out(cle), .addr_latch_out(ale), .write_strobe_n_out(we_n),
    .read_strobe_n_out(re_n), .write_protect_n_out(wp_n), .io_in(io_bus), .io_out(io_h),
    .io_oe_out(oe), .ready_busy_n_in(rb_n), .addr_bytes_out(ab));
  nand_dev_model model_u (.cs_n_in(cs_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
    .re_n_in(re_n), .wp_n_in(wp_n), .io_in(io_bus), .io_out(io_d), .rb_n_out(rb_n));
  task complete_run;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task wait_hi(input sig_dummy);
    integer n;
    begin
      n = 0;
      while ((sig_dummy ? rb_n : rdy) !== 1'b1) begin
        n = n + 1;
        if (n > 3000) begin
          fails = fails + 1;
          complete_run;
        end
        @(posedge clk_sys_in);
      end
    end
  endtask
  task xfer(input [1:0] o, input [7:0] d);
    begin
      rd = 8'hxx;
      @(posedge clk_sys_in);
      wait_hi(1'b0);
      op <= o;
      dat <= d;
      vld <= 1'b1;
      @(posedge clk_sys_in);
      vld <= 1'b0;
      repeat (6) begin
        @(posedge clk_sys_in);
        if (rv === 1'b1) rd = rdat;
      end
    end
  endtask
  task power_on_test;
    begin
      repeat (3) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      xfer(2'h0, 8'h00);
      `CHK("first command", 8'hff, model_u.first_cmd)
      `CHK("protect after init", 1'b0, wp_n)
      $display("power-on test done");
    end
  endtask
  task program_read_test;
    begin
    col <= 13'h1f05;
    page <= 6'h2a;
    blk <= 11'h5c3;
    prot <= 1'b1;
    ld <= 1'b1;
    @(posedge clk_sys_in);
    ld <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    `CHK("address bytes", 40'h0170ea1005, ab)
    `CHK("protect raised", 1'b1, wp_n)
    xfer(2'h0, 8'h80);
    for (i = 0; i < 5; i = i + 1) xfer(2'h1, ab[i*8 +: 8]);
    xfer(2'h2, 8'haa);
    xfer(2'h2, 8'h55);
    ib <= 1'b1;
    xfer(2'h0, 8'h10);
    `CHK("busy line", 1'b0, rb_n)
    xfer(2'h0, 8'h78);
    xfer(2'h3, 8'h00);
    `CHK("status while busy", 8'h80, rd)
    wait_hi(1'b1);
    xfer(2'h3, 8'h00);
    `CHK("status when ready", 8'hc0, rd)
    ib <= 1'b0;
    xfer(2'h0, 8'h00);
    xfer(2'h1, 8'h05);
    xfer(2'h3, 8'h00);
    `CHK("first data", 8'haa, rd)
    xfer(2'h3, 8'h00);
    `CHK("second data", 8'h55, rd)
    `CHK("standby", 1'b1, cs_n)
    $display("program and read test done");
    end
  endtask
  task protect_test;
    begin
      prot <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      xfer(2'h0, 8'h10);
      `CHK("no busy when protected", 1'b1, rb_n)
      xfer(2'h0, 8'h70);
      xfer(2'h3, 8'h00);
      `CHK("protected status", 8'h40, rd)
      $display("protect test done");
    end
  endtask
  initial begin
    power_on_test;
    program_read_test;
    protect_test;
    complete_run;
  end
endmodule // nand_async_host_bench
